// ### dll_ctrl_pkg.sv
package dll_ctrl_pkg;
    // register map, byte offsets on the device register port
    localparam logic [11:0] CTRL_OFFSET = 12'h0091;
    localparam logic [11:0] STATUS_OFFSET = 12'h0092;
    localparam logic [11:0] GUARD_OFFSET = 12'h0093;
    localparam logic [11:0] COARSE_OFFSET = 12'h0094;
    localparam logic [11:0] FINE_OFFSET = 12'h0095;
    localparam logic [11:0] PHASE_OFFSET = 12'h0096;
    localparam logic [11:0] BW_OFFSET = 12'h0097;
    localparam logic [11:0] READ_OFFSET = 12'h0098;
    localparam logic [11:0] COARSE_RB_OFFSET = 12'h0099;
    localparam logic [11:0] FINE_RB_OFFSET = 12'h009a;
    localparam logic [11:0] PHASE_RB_OFFSET = 12'h009b;

    // field widths and positions
    localparam int COARSE_W = 6;
    localparam int FINE_W = 8;
    localparam int PHASE_W = 5;
    localparam int GUARD_W = 4;
    localparam int ENABLE_BIT = 0;
    localparam int MODE_LSB = 1;
    localparam int LOCKED_BIT = 0;
    localparam int LOST_BIT = 1;
    localparam int FAIL_BIT = 2;
    localparam int SPEED_LSB = 0;
    localparam int BW_LSB = 2;
    localparam int READ_BIT = 0;

    // reset values and the desired phase limit
    localparam logic [COARSE_W-1:0] COARSE_RESET = 6'h00;
    localparam logic [FINE_W-1:0] FINE_RESET = 8'h80;
    localparam logic [PHASE_W-1:0] PHASE_RESET = 5'h08;
    localparam logic [PHASE_W-1:0] PHASE_MAX = 5'h10;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // loop step timing: the delay line needs this long to settle per step
    localparam int CLK_PERIOD_PS = 5000;
    localparam int STEP_SETTLE_NS = 40;
    localparam int STEP_CYCLES = (STEP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        MODE_SEARCH_TRACK = 2'b00,
        MODE_TRACK_ONLY = 2'b01,
        MODE_SEARCH_ONLY = 2'b10,
        MODE_RESERVED = 2'b11
    } loop_mode_t;

    typedef struct packed {
        logic [COARSE_W-1:0] coarse;
        logic [FINE_W-1:0] fine;
    } taps_t;

    typedef struct packed {
        logic fail;
        logic lost;
        logic locked;
    } lock_status_t;
endpackage

// ### phase_filter.sv
module phase_filter #(
    parameter int PW = 5,
    parameter int FRAC = 8
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clear_in,
    input wire logic [PW-1:0] phase_in,
    input wire logic [2:0] bandwidth_in,
    output logic [PW-1:0] phase_out
);
    localparam int AW = PW + FRAC;
    logic [AW-1:0] acc;
    logic signed [AW+1:0] diff;
    logic signed [AW+1:0] step;
    logic signed [AW+1:0] bias;
    logic [AW-1:0] next_acc;

    // first-order low pass: larger bandwidth code means slower, quieter filter
    assign diff = $signed({2'b00, phase_in, {FRAC{1'b0}}}) - $signed({2'b00, acc});
    // round a rising step up, else the shift stalls just below the input
    assign bias = diff[AW+1] ? '0 : $signed((AW+2)'((1 << bandwidth_in) - 1));
    assign step = (diff + bias) >>> bandwidth_in;
    assign next_acc = acc + step[AW-1:0];
    assign phase_out = acc[AW-1:FRAC];

    // clear preloads the input so a restart does not drag old history along
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            acc <= '0;
        end else if (clear_in) begin
            acc <= {phase_in, {FRAC{1'b0}}};
        end else begin
            acc <= next_acc;
        end
    end
endmodule

// ### step_divider.sv
module step_divider #(
    parameter int BASE = 8,
    parameter int CW = 16
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic run_in,
    input wire logic [1:0] speed_in,
    output logic step_out
);
    logic [CW-1:0] count;
    logic [CW-1:0] limit;
    logic at_limit;

    // faster tracking speed halves the step period each notch
    assign limit = CW'((BASE << (2'd3 - speed_in)) - 1);
    assign at_limit = (count >= limit);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            count <= '0;
            step_out <= 1'b0;
        end else if (!run_in) begin
            count <= '0;
            step_out <= 1'b0;
        end else begin
            count <= at_limit ? '0 : count + 1'b1;
            step_out <= at_limit;
        end
    end
endmodule

// ### dll_clock_controller.sv
// Operation
// - enable runs loop; disabled taps follow setpoints
// - status bit 2 flags failure to lock
// - status bit 1 sticky lost lock while tracking, writable
// - status bit 0 shows lock achieved
// - writable coarse setpoint, resets to zero
// - eight-bit fine setpoint, resets to 0x80
// - filter bandwidth [4:2], tracking speed [1:0]
// - read request rising edge captures snapshots
// - six-bit coarse snapshot, resets zero
// - fine and phase snapshots, reset zero
module dll_clock_controller (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [11:0] reg_addr_in,
    input wire logic reg_wr_en_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [dll_ctrl_pkg::PHASE_W-1:0] measured_phase_in,
    output dll_ctrl_pkg::taps_t delay_taps_out,
    output dll_ctrl_pkg::lock_status_t lock_status_out
);
    import dll_ctrl_pkg::*;

    typedef enum {
        ST_IDLE,
        ST_SEARCH,
        ST_TRACK,
        ST_HOLD,
        ST_FAIL
    } loop_state_t;

    // software-visible control state
    logic controller_enable;
    loop_mode_t loop_mode;
    logic [GUARD_W-1:0] guard_band;
    logic [COARSE_W-1:0] coarse_setpoint;
    logic [FINE_W-1:0] fine_setpoint;
    logic [PHASE_W-1:0] desired_phase;
    logic [2:0] phase_filter_bandwidth;
    logic [1:0] tracking_speed;
    logic read_request;
    logic [COARSE_W-1:0] coarse_snapshot;
    logic [FINE_W-1:0] fine_snapshot;
    logic [PHASE_W-1:0] phase_snapshot;

    // loop state
    loop_state_t state;
    loop_state_t next_state;
    taps_t taps;
    taps_t next_taps;
    logic lock_achieved_flag;
    logic lost_flag;
    logic fail_flag;
    logic enable_d;

    // register decode
    logic wr_ctrl;
    logic wr_status;
    logic wr_guard;
    logic wr_coarse;
    logic wr_fine;
    logic wr_phase;
    logic wr_bw;
    logic wr_read;
    assign wr_ctrl = reg_wr_en_in && (reg_addr_in == CTRL_OFFSET);
    assign wr_status = reg_wr_en_in && (reg_addr_in == STATUS_OFFSET);
    assign wr_guard = reg_wr_en_in && (reg_addr_in == GUARD_OFFSET);
    assign wr_coarse = reg_wr_en_in && (reg_addr_in == COARSE_OFFSET);
    assign wr_fine = reg_wr_en_in && (reg_addr_in == FINE_OFFSET);
    assign wr_phase = reg_wr_en_in && (reg_addr_in == PHASE_OFFSET);
    assign wr_bw = reg_wr_en_in && (reg_addr_in == BW_OFFSET);
    assign wr_read = reg_wr_en_in && (reg_addr_in == READ_OFFSET);

    // phase measurement path
    logic [PHASE_W-1:0] filtered_phase;
    logic filter_clear;
    logic step_en;
    logic loop_run;
    assign loop_run = controller_enable && (state != ST_IDLE) && (state != ST_FAIL);
    assign filter_clear = !controller_enable;

    phase_filter #(
        .PW(PHASE_W),
        .FRAC(8)
    ) u_filter (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .clear_in(filter_clear),
        .phase_in(measured_phase_in),
        .bandwidth_in(phase_filter_bandwidth),
        .phase_out(filtered_phase)
    );

    step_divider #(
        .BASE(STEP_CYCLES),
        .CW(16)
    ) u_step (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .run_in(loop_run),
        .speed_in(tracking_speed),
        .step_out(step_en)
    );

    // phase error against target, and guard band comparison
    logic signed [PHASE_W+1:0] phase_err;
    logic [PHASE_W+1:0] err_mag;
    logic in_guard;
    logic err_high;
    assign phase_err = $signed({2'b00, filtered_phase}) - $signed({2'b00, desired_phase});
    assign err_mag = phase_err[PHASE_W+1] ? $unsigned(-phase_err) : $unsigned(phase_err);
    assign in_guard = (err_mag <= {3'b000, guard_band});
    assign err_high = !phase_err[PHASE_W+1];

    // search sweeps fine first, then carries into coarse; end of range fails
    logic fine_at_end;
    logic coarse_at_end;
    assign fine_at_end = (taps.fine == {FINE_W{1'b1}});
    assign coarse_at_end = (taps.coarse == {COARSE_W{1'b1}});
    logic search_exhausted;
    assign search_exhausted = fine_at_end && coarse_at_end;

    // search-only mode parks after lock; reserved code behaves as search-track
    logic wants_track;
    assign wants_track = (loop_mode != MODE_SEARCH_ONLY);

    // loop controller next state and taps
    always_comb begin
        next_state = state;
        next_taps = taps;
        case (state)
            ST_IDLE: begin
                next_taps = '{coarse: coarse_setpoint, fine: fine_setpoint};
                if (controller_enable && !enable_d) begin
                    next_state = (loop_mode == MODE_TRACK_ONLY) ? ST_TRACK : ST_SEARCH;
                end
            end
            ST_SEARCH: begin
                if (step_en) begin
                    if (in_guard) begin
                        next_state = wants_track ? ST_TRACK : ST_HOLD;
                    end else if (search_exhausted) begin
                        next_state = ST_FAIL;
                    end else if (fine_at_end) begin
                        next_taps.fine = '0;
                        next_taps.coarse = taps.coarse + 1'b1;
                    end else begin
                        next_taps.fine = taps.fine + 1'b1;
                    end
                end
            end
            ST_TRACK: begin
                // nudge fine tap toward the target, clamped at the ends
                if (step_en && !in_guard) begin
                    if (err_high && (taps.fine != '0)) begin
                        next_taps.fine = taps.fine - 1'b1;
                    end else if (!err_high && !fine_at_end) begin
                        next_taps.fine = taps.fine + 1'b1;
                    end
                end
            end
            ST_HOLD: begin
                next_state = ST_HOLD;
            end
            ST_FAIL: begin
                next_state = ST_FAIL;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // disabling drops back to setpoint following
        if (!controller_enable) begin
            next_state = ST_IDLE;
        end
    end

    // lock evaluation for the status register
    logic next_locked;
    logic lock_drop;
    assign next_locked = ((state == ST_TRACK) || (state == ST_HOLD)) && in_guard
        && controller_enable;
    assign lock_drop = lock_achieved_flag && !next_locked && (state == ST_TRACK);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= ST_IDLE;
            taps <= '{coarse: COARSE_RESET, fine: FINE_RESET};
            enable_d <= 1'b0;
        end else begin
            state <= next_state;
            // feedback or setpoint drives the taps
            taps <= next_taps;
            enable_d <= controller_enable;
        end
    end

    // status flags
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            lock_achieved_flag <= 1'b0;
            lost_flag <= 1'b0;
            fail_flag <= 1'b0;
        end else begin
            lock_achieved_flag <= next_locked;
            if (lock_drop) begin
                lost_flag <= 1'b1;
            end else if (wr_status) begin
                lost_flag <= reg_wdata_in[LOST_BIT];
            end
            if (next_state == ST_FAIL) begin
                fail_flag <= 1'b1;
            end else if (state == ST_IDLE) begin
                fail_flag <= 1'b0;
            end
        end
    end

    // writable configuration
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            controller_enable <= 1'b0;
            loop_mode <= MODE_SEARCH_TRACK;
            guard_band <= '0;
            coarse_setpoint <= COARSE_RESET;
            fine_setpoint <= FINE_RESET;
            desired_phase <= PHASE_RESET;
            phase_filter_bandwidth <= '0;
            tracking_speed <= '0;
            read_request <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                controller_enable <= reg_wdata_in[ENABLE_BIT];
                loop_mode <= loop_mode_t'(reg_wdata_in[MODE_LSB +: 2]);
            end
            if (wr_guard) begin
                guard_band <= reg_wdata_in[GUARD_W-1:0];
            end
            if (wr_coarse) begin
                coarse_setpoint <= reg_wdata_in[COARSE_W-1:0];
            end
            if (wr_fine) begin
                fine_setpoint <= reg_wdata_in[FINE_W-1:0];
            end
            if (wr_phase) begin
                desired_phase <= (reg_wdata_in[PHASE_W-1:0] > PHASE_MAX) ? PHASE_MAX
                    : reg_wdata_in[PHASE_W-1:0];
            end
            if (wr_bw) begin
                phase_filter_bandwidth <= reg_wdata_in[BW_LSB +: 3];
                tracking_speed <= reg_wdata_in[SPEED_LSB +: 2];
            end
            if (wr_read) begin
                read_request <= reg_wdata_in[READ_BIT];
            end
        end
    end

    // snapshot capture only on the 0 to 1 edge of the request bit
    logic read_rise;
    assign read_rise = wr_read && reg_wdata_in[READ_BIT] && !read_request;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            coarse_snapshot <= '0;
            fine_snapshot <= '0;
            phase_snapshot <= '0;
        end else if (read_rise) begin
            coarse_snapshot <= taps.coarse;
            fine_snapshot <= taps.fine;
            phase_snapshot <= filtered_phase;
        end
    end

    // read mux; unmapped addresses read zero
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr_in)
            CTRL_OFFSET: rd_mux = {5'h00, loop_mode, controller_enable};
            STATUS_OFFSET: rd_mux = {5'h00, fail_flag, lost_flag, lock_achieved_flag};
            GUARD_OFFSET: rd_mux = {4'h0, guard_band};
            COARSE_OFFSET: rd_mux = {2'b00, coarse_setpoint};
            FINE_OFFSET: rd_mux = fine_setpoint;
            PHASE_OFFSET: rd_mux = {3'b000, desired_phase};
            BW_OFFSET: rd_mux = {3'b000, phase_filter_bandwidth, tracking_speed};
            READ_OFFSET: rd_mux = {7'h00, read_request};
            COARSE_RB_OFFSET: rd_mux = {2'b00, coarse_snapshot};
            FINE_RB_OFFSET: rd_mux = fine_snapshot;
            PHASE_RB_OFFSET: rd_mux = {3'b000, phase_snapshot};
            default: rd_mux = ZERO_BYTE;
        endcase
    end

    // outputs are registered so the analog side sees glitch-free codes
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= ZERO_BYTE;
            delay_taps_out <= '{coarse: COARSE_RESET, fine: FINE_RESET};
            lock_status_out <= '0;
        end else begin
            reg_rdata_out <= rd_mux;
            delay_taps_out <= taps;
            lock_status_out <= '{fail: fail_flag, lost: lost_flag, locked: lock_achieved_flag};
        end
    end
endmodule

// ### dll_ctrl_monitor.sv
module dll_ctrl_monitor (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [11:0] reg_addr_in,
    input wire logic reg_wr_en_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [dll_ctrl_pkg::PHASE_W-1:0] measured_phase_in,
    input wire dll_ctrl_pkg::taps_t delay_taps_out,
    input wire dll_ctrl_pkg::lock_status_t lock_status_out
);
    import dll_ctrl_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    logic en_seen;
    logic [1:0] mode_seen;
    wire logic wr_ctrl;
    wire logic wr_fine;
    // write decodes seen at the register port
    assign wr_ctrl = reg_wr_en_in && (reg_addr_in == CTRL_OFFSET);
    assign wr_fine = reg_wr_en_in && (reg_addr_in == FINE_OFFSET);
    // shadow of enable and mode, since the ports give no other view of them
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            en_seen <= 1'b0;
            mode_seen <= 2'b00;
        end else if (wr_ctrl) begin
            en_seen <= reg_wdata_in[ENABLE_BIT];
            mode_seen <= reg_wdata_in[MODE_LSB+:2];
        end
    end
    property p_status_rsvd;
        reg_addr_in == STATUS_OFFSET |=> reg_rdata_out[7:3] == 5'h00;
    endproperty
    a_status_rsvd: assert property (p_status_rsvd)
        else $error("status reserved bits set");
    property p_coarse_rsvd;
        reg_addr_in == COARSE_OFFSET |=> reg_rdata_out[7:6] == 2'h0;
    endproperty
    a_coarse_rsvd: assert property (p_coarse_rsvd)
        else $error("coarse setpoint wider than six bits");
    property p_phase_max;
        reg_addr_in == PHASE_OFFSET |=> reg_rdata_out <= 8'h10;
    endproperty
    a_phase_max: assert property (p_phase_max)
        else $error("desired phase above sixteen");
    property p_bw_rsvd;
        reg_addr_in == BW_OFFSET |=> reg_rdata_out[7:5] == 3'h0;
    endproperty
    a_bw_rsvd: assert property (p_bw_rsvd)
        else $error("bandwidth reserved bits set");
    property p_read_rsvd;
        reg_addr_in == READ_OFFSET |=> reg_rdata_out[7:1] == 7'h00;
    endproperty
    a_read_rsvd: assert property (p_read_rsvd)
        else $error("read request reserved bits set");
    property p_coarse_rb;
        reg_addr_in == COARSE_RB_OFFSET |=> reg_rdata_out[7:6] == 2'h0;
    endproperty
    a_coarse_rb: assert property (p_coarse_rb)
        else $error("coarse snapshot wider than six bits");
    property p_phase_rb;
        reg_addr_in == PHASE_RB_OFFSET |=> reg_rdata_out[7:5] == 3'h0;
    endproperty
    a_phase_rb: assert property (p_phase_rb)
        else $error("phase snapshot wider than five bits");
    property p_fail_excl;
        lock_status_out.fail |-> !lock_status_out.locked;
    endproperty
    a_fail_excl: assert property (p_fail_excl)
        else $error("fail and locked both set");
    // two quiet cycles so the setpoint, the tap and the output register settle
    property p_fine_follow;
        wr_fine && !en_seen ##1 (!wr_fine && !wr_ctrl) [*2]
            |=> delay_taps_out.fine == $past(reg_wdata_in, 3);
    endproperty
    a_fine_follow: assert property (p_fine_follow)
        else $error("fine tap does not follow setpoint");
    property p_lost_set;
        $fell(lock_status_out.locked) && en_seen && mode_seen != 2'b10
            |-> ##[0:2] lock_status_out.lost;
    endproperty
    a_lost_set: assert property (p_lost_set)
        else $error("lost flag not set after lock drop");
    c_locked: cover property ($rose(lock_status_out.locked));
    c_lost: cover property ($rose(lock_status_out.lost));
    c_fail: cover property ($rose(lock_status_out.fail));
    c_capture: cover property (reg_wr_en_in && reg_addr_in == READ_OFFSET);
endmodule

bind dll_clock_controller dll_ctrl_monitor i_monitor (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_en_in(reg_wr_en_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out),
    .measured_phase_in(measured_phase_in),
    .delay_taps_out(delay_taps_out),
    .lock_status_out(lock_status_out)
);

// ### dll_clock_controller_test.sv
module dll_clock_controller_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dll_ctrl_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [11:0] reg_addr_in = 12'h0000;
    logic reg_wr_en_in = 1'b0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [7:0] reg_rdata_out;
    logic [PHASE_W-1:0] measured_phase_in = 5'h08;
    taps_t delay_taps_out;
    lock_status_t lock_status_out;
    int bad_count = 0;
    int checks_done = 0;
    // register map and reset values, last entry is an unmapped address
    logic [11:0] ra [12] = '{12'h0091, 12'h0092, 12'h0093, 12'h0094, 12'h0095, 12'h0096,
        12'h0097, 12'h0098, 12'h0099, 12'h009a, 12'h009b, 12'h00a0};
    logic [7:0] rv [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h08,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    always #2.5 clk_in = ~clk_in;
    dll_clock_controller i_dut (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr_in),
        .reg_wr_en_in(reg_wr_en_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out),
        .measured_phase_in(measured_phase_in),
        .delay_taps_out(delay_taps_out),
        .lock_status_out(lock_status_out)
    );
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // inputs move only on the falling edge, away from the sampling edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_en_in = 1'b1;
        @(negedge clk_in);
        reg_wr_en_in = 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        @(negedge clk_in);
        reg_addr_in = a;
        repeat (2) @(negedge clk_in);
        chk(reg_rdata_out, exp);
    endtask
    task automatic wait_flag(input int b, input logic v);
        int n;
        n = 0;
        while (lock_status_out[b] !== v && n < 400) begin
            @(negedge clk_in);
            n++;
        end
        if (lock_status_out[b] !== v) begin
            bad_count++;
            $display("unexpected at %0t: status wait ran out", $time);
            close_out();
        end
    endtask
    task automatic t_reset();
        chk(delay_taps_out, 14'h0080);
        chk(lock_status_out, 3'b000);
        for (int i = 0; i < 12; i++) begin
            rchk(ra[i], rv[i]);
        end
        $display("reset test done");
    endtask
    task automatic t_setpoints();
        wr(COARSE_OFFSET, 8'hff);
        wr(FINE_OFFSET, 8'h5a);
        wr(PHASE_OFFSET, 8'h1f);
        wr(BW_OFFSET, 8'hff);
        rchk(COARSE_OFFSET, 8'h3f);
        rchk(FINE_OFFSET, 8'h5a);
        rchk(PHASE_OFFSET, 8'h10);
        rchk(BW_OFFSET, 8'h1f);
        chk(delay_taps_out, 14'h3f5a);
        $display("setpoint test done");
    endtask
    // every mode, with the measured phase already inside the guard band
    task automatic t_lock();
        wr(PHASE_OFFSET, 8'h08);
        wr(GUARD_OFFSET, 8'h01);
        wr(BW_OFFSET, 8'h03);
        measured_phase_in = 5'h08;
        for (int m = 0; m < 4; m++) begin
            wr(CTRL_OFFSET, 8'h00);
            wr(STATUS_OFFSET, 8'h00);
            wr(CTRL_OFFSET, {5'h00, m[1:0], 1'b1});
            wait_flag(LOCKED_BIT, 1'b1);
            rchk(STATUS_OFFSET, 8'h01);
        end
        measured_phase_in = 5'h10;
        wait_flag(LOST_BIT, 1'b1);
        rchk(STATUS_OFFSET, 8'h02);
        wr(STATUS_OFFSET, 8'h00);
        rchk(STATUS_OFFSET, 8'h00);
        wr(STATUS_OFFSET, 8'h07);
        rchk(STATUS_OFFSET, 8'h02);
        chk(delay_taps_out.fine < 8'h5a, 1'b1);
        wr(CTRL_OFFSET, 8'h00);
        $display("lock test done");
    endtask
    // search from near the top of the range with no guard band
    task automatic t_fail();
        wr(GUARD_OFFSET, 8'h00);
        wr(COARSE_OFFSET, 8'h3f);
        wr(FINE_OFFSET, 8'hf0);
        measured_phase_in = 5'h00;
        wr(STATUS_OFFSET, 8'h00);
        wr(CTRL_OFFSET, 8'h05);
        wait_flag(FAIL_BIT, 1'b1);
        chk(delay_taps_out, 14'h3fff);
        rchk(STATUS_OFFSET, 8'h04);
        wr(STATUS_OFFSET, 8'h00);
        rchk(STATUS_OFFSET, 8'h04);
        wr(CTRL_OFFSET, 8'h00);
        $display("fail test done");
    endtask
    task automatic t_readback();
        wr(COARSE_OFFSET, 8'h15);
        wr(FINE_OFFSET, 8'h33);
        measured_phase_in = 5'h0b;
        wr(READ_OFFSET, 8'h00);
        wr(READ_OFFSET, 8'h01);
        rchk(COARSE_RB_OFFSET, 8'h15);
        rchk(FINE_RB_OFFSET, 8'h33);
        rchk(PHASE_RB_OFFSET, 8'h0b);
        wr(COARSE_OFFSET, 8'h20);
        wr(READ_OFFSET, 8'h01);
        rchk(COARSE_RB_OFFSET, 8'h15);
        rchk(READ_OFFSET, 8'h01);
        wr(READ_OFFSET, 8'h00);
        wr(READ_OFFSET, 8'h01);
        rchk(COARSE_RB_OFFSET, 8'h20);
        $display("readback test done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
        sys_rst_in = 1'b0;
        t_reset();
        t_setpoints();
        t_lock();
        t_fail();
        t_readback();
        close_out();
    end
endmodule
